// >>> hdl/crsse_core.sv
// Executor for option load, literal return, sleep, rotates and subtract
`default_nettype none
// Functional notes
// (RQ1) Option load copies accumulator, flags untouched
// (RQ2) Literal return loads immediate into accumulator
// (RQ3) Literal return pops stack into PC, two cycles
// (RQ4) Sleep clears watchdog counter and prescaler
// (RQ5) Sleep sets timeout flag, clears powerdown flag
// (RQ6) Sleep halts execution until wake
// (RQ7) Rotate left through carry, carry only
// (RQ8) Rotate right through carry, carry only
// (RQ9) Destination bit picks accumulator or file
// (RQ10) Subtract accumulator from file, update C DC Z
// (RQ11) Return discards prefetched instruction, idle cycle
// (RQ12) Subtract carry means no borrow, nibble too
module crsse_core #(
   parameter int PC_W        = 8,
   parameter int STACK_DEPTH = 2
) (
   input  wire logic                        clk_i,
   input  wire logic                        rst_b_i,
   input  wire logic                        instr_valid_i,
   input  wire logic [11:0]                 instr_i,
   input  wire logic [7:0]                  file_rdata_i,
   input  wire logic                        wake_i,
   input  wire logic [3:0]                  addr_i,
   input  wire logic [7:0]                  wdata_i,
   input  wire logic                        wr_i,
   input  wire logic                        rd_i,
   output logic      [7:0]                  rdata_o,
   output logic      [PC_W-1:0]             pc_o,
   output logic      [7:0]                  acc_o,
   output logic      [7:0]                  status_o,
   output logic      [7:0]                  option_o,
   output logic      [4:0]                  file_addr_o,
   output logic      [7:0]                  file_wdata_o,
   output logic                             file_we_o,
   output logic                             wdt_clear_o,
   output logic                             wdt_prescaler_clear_o,
   output logic                             sleep_o,
   output logic                             idle_o
);
   localparam int SCW = $clog2(STACK_DEPTH + 1);

   logic                         rst_s1;
   logic                         rst_n;
   crsse_pkg::crsse_state_type   state;
   crsse_pkg::crsse_state_type   next_state;
   logic [PC_W-1:0]              next_pc;
   logic [7:0]                   next_acc;
   logic [7:0]                   next_status;
   logic [7:0]                   next_option;
   logic [7:0]                   sw_status;
   logic [7:0]                   rd_mux;
   logic [PC_W-1:0]              stack_top;
   logic [SCW-1:0]               stack_count;
   crsse_pkg::crsse_alu_type     alu_out;

   // Reset release through two flops
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // Instruction decode
   wire       run       = (state == crsse_pkg::S_RUN);
   wire       exec      = instr_valid_i && run;
   wire       dest_file = instr_i[crsse_pkg::DEST_BIT];
   wire       is_option = (instr_i == crsse_pkg::OPC_OPTION);
   wire       is_sleep  = (instr_i == crsse_pkg::OPC_SLEEP);
   wire       is_retlit = (instr_i[11:8] == crsse_pkg::OPC_RETLIT);
   wire       is_rotl   = (instr_i[11:6] == crsse_pkg::OPC_ROTL);
   wire       is_rotr   = (instr_i[11:6] == crsse_pkg::OPC_ROTR);
   wire       is_sub    = (instr_i[11:6] == crsse_pkg::OPC_SUB);
   wire crsse_pkg::crsse_op_type dec_op =
      is_option ? crsse_pkg::OP_OPTION :
      is_sleep  ? crsse_pkg::OP_SLEEP  :
      is_retlit ? crsse_pkg::OP_RETLIT :
      is_rotl   ? crsse_pkg::OP_ROTL   :
      is_rotr   ? crsse_pkg::OP_ROTR   :
      is_sub    ? crsse_pkg::OP_SUB    : crsse_pkg::OP_NONE;
   wire       do_option = exec && is_option;
   wire       do_sleep  = exec && is_sleep;
   wire       do_retlit = exec && is_retlit;
   wire       do_alu    = exec && (is_rotl || is_rotr || is_sub);
   wire       do_flags  = exec && is_sub;
   wire       do_carry  = exec && (is_rotl || is_rotr || is_sub);

   // Register port decode
   wire       wr_acc    = wr_i && (addr_i == crsse_pkg::REG_ACC);
   wire       wr_status = wr_i && (addr_i == crsse_pkg::REG_STATUS);
   wire       wr_ctrl   = wr_i && (addr_i == crsse_pkg::REG_CTRL);
   wire       wr_push   = wr_i && (addr_i == crsse_pkg::REG_PUSH);
   wire       sw_wake   = wr_ctrl && wdata_i[crsse_pkg::CTRL_WAKE];
   wire       wake_any  = wake_i || sw_wake;
   wire [7:0] state_rd  = 8'({stack_count, 2'b00, (state == crsse_pkg::S_IDLE),
                               (state == crsse_pkg::S_SLEEP)});

   assign rd_mux =
      (addr_i == crsse_pkg::REG_ACC)    ? acc_o    :
      (addr_i == crsse_pkg::REG_STATUS) ? status_o :
      (addr_i == crsse_pkg::REG_OPTION) ? option_o :
      (addr_i == crsse_pkg::REG_PC)     ? 8'(pc_o) :
      (addr_i == crsse_pkg::REG_STATE)  ? state_rd : 8'h00;

   crsse_alu u_alu (
      .f_i   (file_rdata_i),
      .acc_i (acc_o),
      .c_i   (status_o[crsse_pkg::BIT_C]),
      .dc_i  (status_o[crsse_pkg::BIT_DC]),
      .z_i   (status_o[crsse_pkg::BIT_Z]),
      .op_i  (dec_op),
      .out_o (alu_out)
   );

   crsse_stack #(
      .DEPTH (STACK_DEPTH),
      .W     (PC_W)
   ) u_stack (
      .clk_i   (clk_i),
      .rst_n   (rst_n),
      .push_i  (wr_push),
      .pop_i   (do_retlit),                                     // [RQ3]
      .din_i   (PC_W'(wdata_i)),
      .top_o   (stack_top),
      .count_o (stack_count)
   );

   // Sequencing: return inserts one idle cycle, sleep waits for wake
   always_comb begin
      next_state = state;
      unique case (state)
         crsse_pkg::S_RUN: begin
            if (do_retlit) begin
               next_state = crsse_pkg::S_IDLE;                   // [RQ11]
            end else if (do_sleep) begin
               next_state = crsse_pkg::S_SLEEP;                  // [RQ6]
            end
         end
         crsse_pkg::S_IDLE: begin
            next_state = crsse_pkg::S_RUN;                       // [RQ3]
         end
         crsse_pkg::S_SLEEP: begin
            if (wake_any) begin
               next_state = crsse_pkg::S_RUN;
            end
         end
         default: begin
            next_state = crsse_pkg::S_RUN;
         end
      endcase
   end

   assign next_pc = do_retlit ? stack_top :                     // [RQ3]
                    exec      ? pc_o + PC_W'(1) : pc_o;

   assign next_acc = do_retlit               ? instr_i[7:0] :   // [RQ2]
                     (do_alu && !dest_file)  ? alu_out.res  :   // [RQ9]
                     wr_acc                  ? wdata_i      : acc_o;

   assign next_option = do_option ? acc_o : option_o;           // [RQ1]

   // Software write first, hardware updates override it
   assign sw_status = wr_status ?
      ((status_o & ~crsse_pkg::STATUS_WMASK) | (wdata_i & crsse_pkg::STATUS_WMASK)) :
      status_o;

   always_comb begin
      next_status = sw_status;
      if (do_carry) begin
         next_status[crsse_pkg::BIT_C] = alu_out.c;              // [RQ7] [RQ8] [RQ10]
      end
      if (do_flags) begin
         next_status[crsse_pkg::BIT_DC] = alu_out.dc;            // [RQ12]
         next_status[crsse_pkg::BIT_Z]  = alu_out.z;             // [RQ10]
      end
      if (do_sleep) begin
         next_status[crsse_pkg::BIT_TO] = 1'b1;                  // [RQ5]
         next_status[crsse_pkg::BIT_PD] = 1'b0;                  // [RQ5]
      end
      if (wake_i && (state == crsse_pkg::S_SLEEP)) begin
         next_status[crsse_pkg::BIT_WAKE] = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state    <= crsse_pkg::S_RUN;
         pc_o     <= '0;
         acc_o    <= crsse_pkg::ACC_RST;
         status_o <= crsse_pkg::STATUS_RST;
         option_o <= crsse_pkg::OPTION_RST;
      end else begin
         state    <= next_state;
         pc_o     <= next_pc;
         acc_o    <= next_acc;
         status_o <= next_status;
         option_o <= next_option;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         file_addr_o  <= '0;
         file_wdata_o <= '0;
         file_we_o    <= 1'b0;
      end else begin
         file_addr_o  <= instr_i[4:0];
         file_wdata_o <= alu_out.res;
         file_we_o    <= do_alu && dest_file;                    // [RQ9]
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         wdt_clear_o           <= 1'b0;
         wdt_prescaler_clear_o <= 1'b0;
         sleep_o               <= 1'b0;
         idle_o                <= 1'b0;
         rdata_o               <= 8'h00;
      end else begin
         wdt_clear_o           <= do_sleep;                      // [RQ4]
         wdt_prescaler_clear_o <= do_sleep;                      // [RQ4]
         sleep_o               <= (next_state == crsse_pkg::S_SLEEP);  // [RQ6]
         idle_o                <= (next_state == crsse_pkg::S_IDLE);   // [RQ11]
         rdata_o               <= rd_i ? rd_mux : 8'h00;
      end
   end

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   property p_option_load;
      do_option |=> (option_o == $past(acc_o)) && (status_o[2:0] == $past(status_o[2:0]));
   endproperty
   a_option_load: assert property (p_option_load) else $error("option load wrong"); // [RQ1]

   property p_retlit_acc;
      do_retlit |=> (acc_o == $past(instr_i[7:0])) && (status_o[2:0] == $past(status_o[2:0]));
   endproperty
   a_retlit_acc: assert property (p_retlit_acc) else $error("return literal wrong"); // [RQ2]

   sequence s_idle_then_run;
      idle_o && !file_we_o ##1 !idle_o && (state == crsse_pkg::S_RUN);
   endsequence
   property p_retlit_pc;
      do_retlit |=> (pc_o == $past(stack_top)) and s_idle_then_run;
   endproperty
   a_retlit_pc: assert property (p_retlit_pc) else $error("return timing wrong"); // [RQ3]

   // The idle cycle follows the pc load, so its effects show one cycle later
   property p_idle_discard;
      idle_o |=> $stable(pc_o) && $stable(option_o) && !file_we_o && !wdt_clear_o;
   endproperty
   a_idle_discard: assert property (p_idle_discard) else $error("idle cycle executed"); // [RQ11]

   property p_sleep_wdt;
      do_sleep |=> wdt_clear_o && wdt_prescaler_clear_o ##1 !wdt_clear_o;
   endproperty
   a_sleep_wdt: assert property (p_sleep_wdt) else $error("watchdog not cleared"); // [RQ4]

   property p_sleep_flags;
      do_sleep |=> status_o[crsse_pkg::BIT_TO] && !status_o[crsse_pkg::BIT_PD]
                   && (status_o[crsse_pkg::BIT_WAKE] == $past(status_o[crsse_pkg::BIT_WAKE]));
   endproperty
   a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong"); // [RQ5]

   property p_sleep_halt;
      sleep_o && !wake_any |=> sleep_o && !file_we_o && $stable(pc_o) && $stable(acc_o[7:0]);
   endproperty
   a_sleep_halt: assert property (p_sleep_halt) else $error("ran while asleep"); // [RQ6]

   property p_rotl;
      exec && is_rotl |=> status_o[crsse_pkg::BIT_C] == $past(file_rdata_i[7])
                          && status_o[2:1] == $past(status_o[2:1]);
   endproperty
   a_rotl: assert property (p_rotl) else $error("rotate left carry wrong"); // [RQ7]

   property p_rotr;
      exec && is_rotr && !dest_file |=>
         acc_o == {$past(status_o[crsse_pkg::BIT_C]), $past(file_rdata_i[7:1])};
   endproperty
   a_rotr: assert property (p_rotr) else $error("rotate right wrong"); // [RQ8]

   property p_dest;
      do_alu |=> file_we_o == $past(dest_file)
                 && (!file_we_o || file_addr_o == $past(instr_i[4:0]));
   endproperty
   a_dest: assert property (p_dest) else $error("destination wrong"); // [RQ9]

   property p_sub;
      do_flags |=> status_o[crsse_pkg::BIT_C] == ($past(file_rdata_i) >= $past(acc_o))
                   && status_o[crsse_pkg::BIT_DC] ==
                      ($past(file_rdata_i[3:0]) >= $past(acc_o[3:0]));
   endproperty
   a_sub: assert property (p_sub) else $error("subtract borrow flags wrong"); // [RQ12]

   property p_sub_zero;
      do_flags |=> status_o[crsse_pkg::BIT_Z] == ($past(file_rdata_i) == $past(acc_o));
   endproperty
   a_sub_zero: assert property (p_sub_zero) else $error("subtract zero wrong"); // [RQ10]
endmodule
`default_nettype wire

// >>> hdl/crsse_pkg.sv
// Shared constants and types for the return, sleep, rotate and subtract executor
`default_nettype none
package crsse_pkg;
   localparam int          DATA_W       = 8;
   localparam int          INSTR_W      = 12;
   localparam int          FADDR_W      = 5;
   localparam int          RADDR_W      = 4;
   localparam int          DEST_BIT     = 5;
   // Instruction encodings
   localparam logic [11:0] OPC_OPTION   = 12'h002;
   localparam logic [11:0] OPC_SLEEP    = 12'h003;
   localparam logic [3:0]  OPC_RETLIT   = 4'h8;
   localparam logic [5:0]  OPC_ROTL     = 6'h0D;
   localparam logic [5:0]  OPC_ROTR     = 6'h0C;
   localparam logic [5:0]  OPC_SUB      = 6'h02;
   // Register port offsets
   localparam logic [3:0]  REG_ACC      = 4'h0;
   localparam logic [3:0]  REG_STATUS   = 4'h1;
   localparam logic [3:0]  REG_OPTION   = 4'h2;
   localparam logic [3:0]  REG_PC       = 4'h3;
   localparam logic [3:0]  REG_CTRL     = 4'h4;
   localparam logic [3:0]  REG_PUSH     = 4'h5;
   localparam logic [3:0]  REG_STATE    = 4'h6;
   // Status field positions and values
   localparam int          BIT_C        = 0;
   localparam int          BIT_DC       = 1;
   localparam int          BIT_Z        = 2;
   localparam int          BIT_PD       = 3;
   localparam int          BIT_TO       = 4;
   localparam int          BIT_WAKE     = 7;
   localparam logic [7:0]  STATUS_RST   = 8'h18;
   localparam logic [7:0]  STATUS_WMASK = 8'h87;
   localparam logic [7:0]  OPTION_RST   = 8'hFF;
   localparam logic [7:0]  ACC_RST      = 8'h00;
   localparam int          CTRL_WAKE    = 0;
   // State register field positions
   localparam int          STA_SLEEP    = 0;
   localparam int          STA_IDLE     = 1;
   localparam int          STA_DEPTH    = 4;

   typedef enum logic [2:0] {
      OP_NONE   = 3'b000,
      OP_OPTION = 3'b001,
      OP_RETLIT = 3'b010,
      OP_SLEEP  = 3'b011,
      OP_ROTL   = 3'b100,
      OP_ROTR   = 3'b101,
      OP_SUB    = 3'b110
   } crsse_op_type;

   typedef enum logic [1:0] {
      S_RUN   = 2'b00,
      S_IDLE  = 2'b01,
      S_SLEEP = 2'b10
   } crsse_state_type;

   typedef struct packed {
      logic [7:0] res;
      logic       c;
      logic       dc;
      logic       z;
   } crsse_alu_type;
endpackage
`default_nettype wire

// >>> hdl/crsse_alu.sv
// Rotate through carry and subtract datapath with flag results
`default_nettype none
module crsse_alu (
   input  wire logic [7:0]            f_i,
   input  wire logic [7:0]            acc_i,
   input  wire logic                  c_i,
   input  wire logic                  dc_i,
   input  wire logic                  z_i,
   input  wire crsse_pkg::crsse_op_type op_i,
   output var  crsse_pkg::crsse_alu_type out_o
);
   logic [8:0] diff;
   logic [4:0] ndiff;

   // Two's complement: f + ~acc + 1
   assign diff  = {1'b0, f_i} + {1'b0, ~acc_i} + 9'h001;       // [RQ10]
   assign ndiff = {1'b0, f_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;

   always_comb begin
      out_o = '{res: f_i, c: c_i, dc: dc_i, z: z_i};
      unique case (op_i)
         crsse_pkg::OP_ROTL: begin
            out_o.res = {f_i[6:0], c_i};                         // [RQ7]
            out_o.c   = f_i[7];                                  // [RQ7]
         end
         crsse_pkg::OP_ROTR: begin
            out_o.res = {c_i, f_i[7:1]};                         // [RQ8]
            out_o.c   = f_i[0];                                  // [RQ8]
         end
         crsse_pkg::OP_SUB: begin
            out_o.res = diff[7:0];                               // [RQ10]
            out_o.c   = diff[8];                                 // [RQ12]
            out_o.dc  = ndiff[4];                                // [RQ12]
            out_o.z   = (diff[7:0] == 8'h00);                    // [RQ10]
         end
         default: begin
         end
      endcase
   end
endmodule
`default_nettype wire

// >>> hdl/crsse_stack.sv
// Hardware return address stack with shift entries
`default_nettype none
module crsse_stack #(
   parameter int DEPTH = 2,
   parameter int W     = 8
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_n,
   input  wire logic                       push_i,
   input  wire logic                       pop_i,
   input  wire logic [W-1:0]               din_i,
   output logic      [W-1:0]               top_o,
   output logic      [$clog2(DEPTH+1)-1:0] count_o
);
   localparam int CW = $clog2(DEPTH+1);
   logic [W-1:0] mem [DEPTH];

   assign top_o = mem[0];

   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_entry
         always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
               mem[gi] <= '0;
            end else if (push_i && pop_i) begin
               if (gi == 0) begin
                  mem[gi] <= din_i;
               end
            end else if (push_i) begin
               mem[gi] <= (gi == 0) ? din_i : mem[(gi > 0) ? gi - 1 : 0];
            end else if (pop_i) begin
               if (gi < DEPTH - 1) begin
                  mem[gi] <= mem[(gi < DEPTH - 1) ? gi + 1 : gi];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         count_o <= '0;
      end else if (push_i && !pop_i && count_o != CW'(DEPTH)) begin
         count_o <= count_o + CW'(1);
      end else if (pop_i && !push_i && count_o != '0) begin
         count_o <= count_o - CW'(1);
      end
   end
endmodule
`default_nettype wire

// >>> tb/crsse_tb.sv
// Self-checking bench for the return, sleep, rotate and subtract executor
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        instr_valid_i = 1'b0;
   logic [11:0] instr_i = 12'h000;
   logic [7:0]  file_rdata_i = 8'h00;
   logic        wake_i = 1'b0;
   logic [3:0]  addr_i = 4'h0;
   logic [7:0]  wdata_i = 8'h00;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [7:0]  rdata_o, pc_o, acc_o, status_o, option_o, file_wdata_o;
   logic [4:0]  file_addr_o, fa;
   logic        file_we_o, wdt_clear_o, wdt_prescaler_clear_o, sleep_o, idle_o, d;
   int          failures = 0;
   int          num_checks = 0;
   logic [7:0]  m_acc, m_status, m_option, m_pc, m_res, f, w, k, rv;
   logic [7:0]  m_stack[$];
   logic [8:0]  diff;
   logic [4:0]  nib;
   logic [5:0]  op6;

   always #12.5 clk_i = ~clk_i;

   crsse_core #(.PC_W(8), .STACK_DEPTH(2)) u_crsse_core (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .file_rdata_i(file_rdata_i), .wake_i(wake_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .pc_o(pc_o), .acc_o(acc_o), .status_o(status_o),
      .option_o(option_o), .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o),
      .file_we_o(file_we_o), .wdt_clear_o(wdt_clear_o),
      .wdt_prescaler_clear_o(wdt_prescaler_clear_o), .sleep_o(sleep_o),
      .idle_o(idle_o));

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      v = rdata_o;
   endtask

   task automatic exec(input logic [11:0] op, input logic [7:0] fd);
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_i <= op;
      file_rdata_i <= fd;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1;
   endtask

   task automatic wait_run();
      int n;
      n = 0;
      #1;
      while (sleep_o !== 1'b0 && n < 8) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      if (sleep_o !== 1'b0) begin
         failures++;
         $display("ERROR sleep_o expected 0 seen %b", sleep_o);
         conclude();
      end
   endtask

   task automatic check_core();
      check("acc", acc_o, m_acc);
      check("status", status_o, m_status);
      check("option", option_o, m_option);
   endtask

   initial begin
      void'($urandom(32'h9970));
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      m_acc = crsse_pkg::ACC_RST;
      m_status = crsse_pkg::STATUS_RST;
      m_option = crsse_pkg::OPTION_RST;
      m_pc = 8'h00;
      check_core();
      reg_wr(crsse_pkg::REG_OPTION, 8'h00);
      reg_rd(crsse_pkg::REG_OPTION, rv);
      check("option rd", rv, 8'hFF);
      reg_rd(4'hF, rv);
      check("unmapped rd", rv, 8'h00);
      $display("test reset done");
      // Option load with the C, DC and Z flags set
      m_acc = 8'($urandom);
      reg_wr(crsse_pkg::REG_ACC, m_acc);
      reg_wr(crsse_pkg::REG_STATUS, 8'h07);
      m_status = m_status | 8'h07;
      exec(crsse_pkg::OPC_OPTION, 8'h00);
      m_option = m_acc;
      m_pc++;
      check_core();
      check("pc", pc_o, m_pc);
      $display("test option done");
      // Rotates and subtract, random operands and destination
      for (int i = 0; i < 30; i++) begin
         m_acc = 8'($urandom);
         f = (i % 7 == 2) ? m_acc : 8'($urandom);
         w = 8'($urandom) & 8'h07;
         d = 1'($urandom);
         fa = 5'($urandom);
         reg_wr(crsse_pkg::REG_ACC, m_acc);
         reg_wr(crsse_pkg::REG_STATUS, w);
         m_status = (m_status & 8'hF8) | w;
         if (i % 3 == 0) begin
            op6 = crsse_pkg::OPC_ROTL;
            m_res = {f[6:0], m_status[0]};
            m_status[0] = f[7];
         end else if (i % 3 == 1) begin
            op6 = crsse_pkg::OPC_ROTR;
            m_res = {m_status[0], f[7:1]};
            m_status[0] = f[0];
         end else begin
            op6 = crsse_pkg::OPC_SUB;
            diff = {1'b0, f} + {1'b0, ~m_acc} + 9'h001;
            nib = {1'b0, f[3:0]} + {1'b0, ~m_acc[3:0]} + 5'h01;
            m_res = diff[7:0];
            m_status[0] = diff[8];
            m_status[1] = nib[4];
            m_status[2] = (m_res == 8'h00);
         end
         exec({op6, d, fa}, f);
         m_pc++;
         if (d) begin
            check("file_addr", 8'(file_addr_o), 8'(fa));
            check("file_wdata", file_wdata_o, m_res);
         end else begin
            m_acc = m_res;
         end
         check("file_we", 8'(file_we_o), 8'(d));
         check_core();
         check("pc", pc_o, m_pc);
      end
      $display("test alu done");
      // Two returns, the second after the idle cycle and one empty cycle; the word offered in the idle cycle is dropped
      reg_wr(crsse_pkg::REG_PUSH, 8'h3C);
      m_stack.push_back(8'h3C);
      reg_wr(crsse_pkg::REG_PUSH, 8'hA5);
      m_stack.push_back(8'hA5);
      reg_rd(crsse_pkg::REG_STATE, rv);
      check("state", rv, 8'h20);
      k = ~m_option;
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_i <= {crsse_pkg::OPC_RETLIT, k};
      @(posedge clk_i);
      instr_i <= crsse_pkg::OPC_OPTION;
      #1;
      m_acc = k;
      m_pc = m_stack.pop_back();
      check_core();
      check("pc", pc_o, m_pc);
      check("idle", 8'(idle_o), 8'h01);
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1;
      check("idle", 8'(idle_o), 8'h00);
      check_core();
      check("pc", pc_o, m_pc);
      exec({crsse_pkg::OPC_RETLIT, 8'h00}, 8'h00);
      m_acc = 8'h00;
      m_pc = m_stack.pop_back();
      check("pc", pc_o, m_pc);
      check_core();
      reg_rd(crsse_pkg::REG_STATE, rv);
      check("state", rv, 8'h00);
      $display("test return done");
      // Sleep, a dropped word while asleep, pin wake, then software wake
      m_acc = ~m_option;
      reg_wr(crsse_pkg::REG_ACC, m_acc);
      for (int s = 0; s < 2; s++) begin
         exec(crsse_pkg::OPC_SLEEP, 8'h00);
         m_status = (m_status | 8'h10) & 8'hF7;
         m_pc++;
         check("pc", pc_o, m_pc);
         check("wdt_clear", 8'(wdt_clear_o), 8'h01);
         check("prescaler", 8'(wdt_prescaler_clear_o), 8'h01);
         check("sleep", 8'(sleep_o), 8'h01);
         check_core();
         exec(crsse_pkg::OPC_OPTION, 8'h00);
         check("wdt_clear", 8'(wdt_clear_o), 8'h00);
         check("prescaler", 8'(wdt_prescaler_clear_o), 8'h00);
         check("pc", pc_o, m_pc);
         check_core();
         if (s == 0) begin
            @(posedge clk_i);
            wake_i <= 1'b1;
            @(posedge clk_i);
            wake_i <= 1'b0;
            m_status[7] = 1'b1;
         end else begin
            reg_wr(crsse_pkg::REG_CTRL, 8'h01);
         end
         wait_run();
         check("status", status_o, m_status);
      end
      exec(crsse_pkg::OPC_OPTION, 8'h00);
      m_option = m_acc;
      m_pc++;
      check_core();
      check("pc", pc_o, m_pc);
      reg_wr(crsse_pkg::REG_STATUS, 8'h00);
      m_status = m_status & 8'h78;
      reg_rd(crsse_pkg::REG_STATUS, rv);
      check("status rd", rv, m_status);
      @(posedge clk_i);
      #1;
      check("rdata idle", rdata_o, 8'h00);
      $display("test sleep done");
      conclude();
   end
endmodule
`default_nettype wire
